// >>> logic/cara_pkg.sv
// shared constants and carrier types for the codec agc / adc path register bank
package cara_pkg;

  // ----------------------------------------------------------------
  // register map (page 0 unless noted)
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_PAGE_SELECT  = 7'h00;
  localparam logic [6:0] ADDR_RIGHT_DECAY  = 7'h6A;
  localparam logic [6:0] ADDR_ADC_PATH     = 7'h6B;
  localparam logic [6:0] ADDR_BYPASS       = 7'h6C;
  localparam logic [6:0] ADDR_DAC_CURRENT  = 7'h6D;
  localparam logic [6:0] ADDR_RSVD_FIRST   = 7'h6E;
  localparam logic [7:0] RESET_BYTE        = 8'h00;
  localparam logic [7:0] ZERO_BYTE         = 8'h00;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int DECAY_SEL_BIT   = 7;
  localparam int DECAY_BASE_LSB  = 5;
  localparam int DECAY_MULT_LSB  = 2;
  localparam int HPF_LEFT_BIT    = 7;
  localparam int HPF_RIGHT_BIT   = 6;
  localparam int MIC_CFG_LSB     = 4;
  localparam int PROG_FILT_BIT   = 3;
  localparam int BUS_DET_BIT     = 2;
  localparam int BUS_ERR_BIT     = 0;
  localparam int DAC_CUR_LSB     = 6;
  localparam int PAGE_BIT        = 0;

  // writable fields of the adc path register (d7-d2)
  localparam logic [7:0] ADC_PATH_WMASK = 8'hFC;

  // ----------------------------------------------------------------
  // decay times in milliseconds
  // ----------------------------------------------------------------
  localparam int MS_W = 16;
  localparam logic [MS_W-1:0] BASE_DECAY_0_MS = 16'h0032;  // 50 ms
  localparam logic [MS_W-1:0] BASE_DECAY_1_MS = 16'h0096;  // 150 ms
  localparam logic [MS_W-1:0] BASE_DECAY_2_MS = 16'h00FA;  // 250 ms
  localparam logic [MS_W-1:0] BASE_DECAY_3_MS = 16'h015E;  // 350 ms

  // ceilings per decimation ratio, in ms
  localparam logic [MS_W-1:0] CEIL_R1_MS   = 16'h0FA0;  // 4 s
  localparam logic [MS_W-1:0] CEIL_R1H_MS  = 16'h15E0;  // 5.6 s
  localparam logic [MS_W-1:0] CEIL_R2_MS   = 16'h1F40;  // 8 s
  localparam logic [MS_W-1:0] CEIL_R2H_MS  = 16'h2580;  // 9.6 s
  localparam logic [MS_W-1:0] CEIL_R3_MS   = 16'h2BC0;  // 11.2 s
  localparam logic [MS_W-1:0] CEIL_R4_MS   = 16'h3E80;  // 16 s
  localparam logic [MS_W-1:0] CEIL_R5_MS   = 16'h4B00;  // 19.2 s
  localparam logic [MS_W-1:0] CEIL_R5H_MS  = 16'h5780;  // 22.4 s

  // decimation ratio code: (ratio - 1) * 2, so 1.0 -> 0 ... 6.0 -> 10
  localparam logic [3:0] RATIO_1   = 4'h0;
  localparam logic [3:0] RATIO_1H  = 4'h1;
  localparam logic [3:0] RATIO_2   = 4'h2;
  localparam logic [3:0] RATIO_2H  = 4'h3;
  localparam logic [3:0] RATIO_3   = 4'h4;
  localparam logic [3:0] RATIO_3H  = 4'h5;
  localparam logic [3:0] RATIO_4   = 4'h6;
  localparam logic [3:0] RATIO_4H  = 4'h7;
  localparam logic [3:0] RATIO_5   = 4'h8;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MIC_BOTH_DIGITAL   = 2'h0,
    MIC_LDIG_RANALOG   = 2'h1,
    MIC_LANALOG_RDIG   = 2'h2,
    MIC_BOTH_ANALOG    = 2'h3
  } cara_mic_cfg_t;

  typedef enum logic [1:0] {
    DAC_CUR_DEFAULT  = 2'h0,
    DAC_CUR_PLUS50   = 2'h1,
    DAC_CUR_RSVD     = 2'h2,
    DAC_CUR_PLUS100  = 2'h3
  } cara_dac_cur_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cara_reg_req_t;

  typedef struct packed {
    logic second_right_in_neg;  // to right_lineout_neg
    logic second_right_in_pos;  // to right_lineout_pos
    logic first_right_in_neg;   // to right_lineout_neg
    logic first_right_in_pos;   // to right_lineout_pos
    logic second_left_in_neg;   // to left_lineout_neg
    logic second_left_in_pos;   // to left_lineout_pos
    logic first_left_in_neg;    // to left_lineout_neg
    logic first_left_in_pos;    // to left_lineout_pos
  } cara_bypass_t;

  typedef struct packed {
    logic          hpf_left_prog;
    logic          hpf_right_prog;
    cara_mic_cfg_t mic_cfg;
    logic          prog_filter_on;
  } cara_adc_path_t;

endpackage

// >>> logic/cara_regs.sv
// page-0 upper register bank: right agc decay override, adc path, bypass, dac current
`timescale 1ns/1ns
module cara_regs (
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  // register port
  input  wire cara_pkg::cara_reg_req_t  req_i,
  output logic [7:0]                    rdata_o,
  output logic                          page_o,
  // agc decay inputs
  input  wire logic [cara_pkg::MS_W-1:0] legacy_decay_ms_i,
  input  wire logic [3:0]               adc_decimation_ratio_i,
  // power and bus monitor inputs
  input  wire logic                     dacs_powered_down_i,
  input  wire logic                     bus_error_event_i,
  // configuration outputs
  output logic [cara_pkg::MS_W-1:0]     right_decay_ms_o,
  output cara_pkg::cara_adc_path_t      adc_path_o,
  output logic                          bus_detect_on_o,
  output logic                          bus_error_clear_o,
  output cara_pkg::cara_bypass_t        bypass_o,
  output cara_pkg::cara_dac_cur_t       dac_current_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // derived outputs are registered here too, one edge behind their fields
  typedef struct packed {
    logic                         page;
    logic [7:0]                   decay;
    logic [7:0]                   adc_path;
    logic                         bus_err;
    logic [7:0]                   bypass;
    logic [7:0]                   dac_cur;
    logic [7:0]                   rdata;
    logic [cara_pkg::MS_W-1:0]    decay_ms;
    logic                         prog_on;
    logic                         clr_pulse;
  } cara_state_t;

  // st_r is the only state; st_nxt is its combinational copy
  cara_state_t st_r;
  cara_state_t st_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ceiling in ms for a decimation ratio code
  // codes above eight have no ceiling of their own and fall to the top one,
  // so a stray code lengthens the decay rather than clipping it short
  function automatic logic [cara_pkg::MS_W-1:0] ceil_ms(input logic [3:0] ratio);
    logic [cara_pkg::MS_W-1:0] c;
    c = cara_pkg::CEIL_R5H_MS;
    if (ratio == cara_pkg::RATIO_1)       c = cara_pkg::CEIL_R1_MS;
    else if (ratio == cara_pkg::RATIO_1H) c = cara_pkg::CEIL_R1H_MS;
    else if (ratio == cara_pkg::RATIO_2)  c = cara_pkg::CEIL_R2_MS;
    else if (ratio == cara_pkg::RATIO_2H) c = cara_pkg::CEIL_R2H_MS;
    else if (ratio == cara_pkg::RATIO_3 || ratio == cara_pkg::RATIO_3H)
      c = cara_pkg::CEIL_R3_MS;
    else if (ratio == cara_pkg::RATIO_4 || ratio == cara_pkg::RATIO_4H)
      c = cara_pkg::CEIL_R4_MS;
    else if (ratio == cara_pkg::RATIO_5)  c = cara_pkg::CEIL_R5_MS;
    return c;
  endfunction

  // baseline decay for a two-bit code
  function automatic logic [cara_pkg::MS_W-1:0] base_ms(input logic [1:0] code);
    logic [cara_pkg::MS_W-1:0] b;
    unique case (code)
      2'h0: b = cara_pkg::BASE_DECAY_0_MS;
      2'h1: b = cara_pkg::BASE_DECAY_1_MS;
      2'h2: b = cara_pkg::BASE_DECAY_2_MS;
      2'h3: b = cara_pkg::BASE_DECAY_3_MS;
    endcase
    return b;
  endfunction

  // page-0 address hit, decoded for both read and write
  // the page register is decoded without it, as it answers on both pages
  function automatic logic hit0(input logic page, input logic [6:0] a, input logic [6:0] r);
    return !page && (a == r);
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // working values of the decay path and the bus-detect enable, kept out of the state so they add no flops
  logic [1:0]                 base_code;
  logic [2:0]                 mult_code;
  logic [cara_pkg::MS_W+7:0]  scaled;
  logic [cara_pkg::MS_W-1:0]  ceiling;
  logic                       det_on;

  always_comb begin
    // hold every field by default; only strobes and derived values move
    st_nxt    = st_r;
    base_code = st_r.decay[cara_pkg::DECAY_BASE_LSB +: 2];
    mult_code = st_r.decay[cara_pkg::DECAY_MULT_LSB +: 3];
    det_on    = st_r.adc_path[cara_pkg::BUS_DET_BIT];

    // baseline shifted by the multiplier code, widened so 350 x 128 cannot wrap
    // a change of ratio alone moves the ceiling on the next edge
    scaled  = {8'h00, base_ms(base_code)} << mult_code;
    ceiling = ceil_ms(adc_decimation_ratio_i);

    // decay source select and ceiling
    // the legacy value passes uncapped; its own register owns that limit
    if (!st_r.decay[cara_pkg::DECAY_SEL_BIT]) begin
      st_nxt.decay_ms = legacy_decay_ms_i;
    end else if (scaled > {8'h00, ceiling}) begin
      st_nxt.decay_ms = ceiling;
    end else begin
      st_nxt.decay_ms = scaled[cara_pkg::MS_W-1:0];
    end

    // programmable filter only when both dacs are down
    // the dacs level is sampled every edge, so a dac powering up drops the filter
    st_nxt.prog_on = st_r.adc_path[cara_pkg::PROG_FILT_BIT] && dacs_powered_down_i;

    // bus-error clear strobe follows each detected error while enabled
    // one strobe per event cycle; a held event input would repeat it
    st_nxt.clr_pulse = det_on && bus_error_event_i;

    // register writes; reserved block writes and page 1 writes other than to the page register are dropped
    // reserved bits of the decay, bypass and current registers are kept as
    // written so read-back shows what the host sent; d1 and status d0 of the
    // adc path register are masked because neither is writable
    if (req_i.wr) begin
      if (req_i.addr == cara_pkg::ADDR_PAGE_SELECT)
        st_nxt.page = req_i.wdata[cara_pkg::PAGE_BIT];
      if (hit0(st_r.page, req_i.addr, cara_pkg::ADDR_RIGHT_DECAY))
        st_nxt.decay = req_i.wdata;
      if (hit0(st_r.page, req_i.addr, cara_pkg::ADDR_ADC_PATH))
        st_nxt.adc_path = req_i.wdata & cara_pkg::ADC_PATH_WMASK;
      if (hit0(st_r.page, req_i.addr, cara_pkg::ADDR_BYPASS))
        st_nxt.bypass = req_i.wdata;
      if (hit0(st_r.page, req_i.addr, cara_pkg::ADDR_DAC_CURRENT))
        st_nxt.dac_cur = req_i.wdata;
    end

    // reads: data registered, unmapped and reserved addresses give zero
    // the read data holds until the next read, so a slow host may pick it
    // up late without a second strobe
    if (req_i.rd) begin
      st_nxt.rdata = cara_pkg::ZERO_BYTE;
      if (req_i.addr == cara_pkg::ADDR_PAGE_SELECT)
        st_nxt.rdata = {7'h00, st_r.page};
      else if (hit0(st_r.page, req_i.addr, cara_pkg::ADDR_RIGHT_DECAY))
        st_nxt.rdata = st_r.decay;
      else if (hit0(st_r.page, req_i.addr, cara_pkg::ADDR_ADC_PATH))
        st_nxt.rdata = st_r.adc_path | {7'h00, st_r.bus_err};
      else if (hit0(st_r.page, req_i.addr, cara_pkg::ADDR_BYPASS))
        st_nxt.rdata = st_r.bypass;
      else if (hit0(st_r.page, req_i.addr, cara_pkg::ADDR_DAC_CURRENT))
        st_nxt.rdata = st_r.dac_cur;
    end

    // error flag: read clears, a new error in the same cycle wins
    // set beats clear so an error landing during the status read is still
    // seen by the next read instead of being lost
    if (req_i.rd && hit0(st_r.page, req_i.addr, cara_pkg::ADDR_ADC_PATH))
      st_nxt.bus_err = 1'b0;
    if (det_on && bus_error_event_i)
      st_nxt.bus_err = 1'b1;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // async reset to all zeros; no field has a non-zero reset value, and the
  // derived decay refills from its inputs on the first edge after release
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign rdata_o                   = st_r.rdata;
  assign page_o                    = st_r.page;
  assign right_decay_ms_o          = st_r.decay_ms;
  // adc path fields in one assignment; the filter flag is already qualified
  assign adc_path_o                = '{
    hpf_left_prog:  st_r.adc_path[cara_pkg::HPF_LEFT_BIT],
    hpf_right_prog: st_r.adc_path[cara_pkg::HPF_RIGHT_BIT],
    mic_cfg:
      cara_pkg::cara_mic_cfg_t'(st_r.adc_path[cara_pkg::MIC_CFG_LSB +: 2]),
    prog_filter_on: st_r.prog_on
  };
  assign bus_detect_on_o           = st_r.adc_path[cara_pkg::BUS_DET_BIT];
  assign bus_error_clear_o         = st_r.clr_pulse;
  // bypass bits drive the switches as they stand; shorting two inputs onto
  // one output is for the host to avoid, the bank does not police it
  assign bypass_o                  = cara_pkg::cara_bypass_t'(st_r.bypass);
  // reserved current code is passed through unchanged
  assign dac_current_o             =
    cara_pkg::cara_dac_cur_t'(st_r.dac_cur[cara_pkg::DAC_CUR_LSB +: 2]);

endmodule

// >>> bench/cara_host_model.sv
// host model: drives single-byte strobes on the bank's register port
`timescale 1ns/1ns
module cara_host_model (
  // clock and read data
  input  wire logic               clock_i,
  input  wire logic [7:0]         rdata_i,
  // request toward the bank
  output cara_pkg::cara_reg_req_t req_o
);
  initial req_o = '0;

  // one strobe cycle per byte; an edge passes before the next strobe
  task automatic wr(input logic [6:0] a, input logic [7:0] dv);
    @(posedge clock_i) #10 req_o = '{1'b1, 1'b0, a, dv};
    @(posedge clock_i) #10 req_o.wr = 1'b0;
  endtask

  // data is registered on the taking edge, picked up once settled
  task automatic rd(input logic [6:0] a, output logic [7:0] dv);
    @(posedge clock_i) #10 req_o = '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i) #10 req_o.rd = 1'b0;
    dv = rdata_i;
  endtask
endmodule

// >>> bench/cara_regs_sva.sv
// checker for the page-0 upper register bank
`timescale 1ns/1ns
module cara_regs_chk (
  // clock, reset and register port
  input wire logic                      clock_i,
  input wire logic                      rst_i,
  input wire cara_pkg::cara_reg_req_t   req_i,
  input wire logic [7:0]                rdata_o,
  input wire logic                      page_o,
  // side inputs
  input wire logic [cara_pkg::MS_W-1:0] legacy_decay_ms_i,
  input wire logic [3:0]                adc_decimation_ratio_i,
  input wire logic                      dacs_powered_down_i,
  input wire logic                      bus_error_event_i,
  // configuration outputs
  input wire logic [cara_pkg::MS_W-1:0] right_decay_ms_o,
  input wire cara_pkg::cara_adc_path_t  adc_path_o,
  input wire logic                      bus_detect_on_o,
  input wire logic                      bus_error_clear_o,
  input wire cara_pkg::cara_bypass_t    bypass_o,
  input wire cara_pkg::cara_dac_cur_t   dac_current_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // page-0 writes only; page 1 ignores all but the page register
  logic w0;
  assign w0 = req_i.wr && !page_o;

  bypass_wr_a: assert property (w0 && req_i.addr == 7'h6C
    |=> bypass_o == $past(req_i.wdata)) else $error("bypass write lost");
  dac_cur_a: assert property (w0 && req_i.addr == 7'h6D
    |=> dac_current_o == $past(req_i.wdata[7:6])) else $error("dac current wrong");
  adc_fields_a: assert property (w0 && req_i.addr == 7'h6B
    |=> adc_path_o[4:1] == $past(req_i.wdata[7:4]) && bus_detect_on_o == $past(req_i.wdata[2]))
    else $error("adc path fields wrong");
  page_sel_a: assert property (req_i.wr && req_i.addr == 7'h00
    |=> page_o == $past(req_i.wdata[0])) else $error("page select wrong");
  rsvd_zero_a: assert property (req_i.rd && req_i.addr >= 7'h6E
    |=> rdata_o == 8'h00) else $error("reserved read not zero");
  err_clear_a: assert property (bus_error_event_i && bus_detect_on_o
    |=> bus_error_clear_o) else $error("bus error not cleared");
  clear_cause_a: assert property (bus_error_clear_o
    |-> $past(bus_error_event_i && bus_detect_on_o)) else $error("spurious bus clear");
  prog_filt_a: assert property (adc_path_o.prog_filter_on
    |-> $past(dacs_powered_down_i)) else $error("filter on with dacs up");
  decay_cap_a: assert property ((w0 && req_i.addr == 7'h6A && req_i.wdata[7])
    ##1 !req_i.wr |=> right_decay_ms_o <= 16'h5780) else $error("decay above ceiling");
  legacy_sel_a: assert property ((w0 && req_i.addr == 7'h6A && !req_i.wdata[7])
    ##1 (!req_i.wr && $stable(legacy_decay_ms_i))
    |=> right_decay_ms_o == $past(legacy_decay_ms_i)) else $error("legacy decay not used");

  // main scenarios reached
  bus_err_c: cover property (bus_error_clear_o);
  page1_c: cover property (page_o && req_i.wr);
  prog_c: cover property (adc_path_o.prog_filter_on);
endmodule

bind cara_regs cara_regs_chk u_chk (.*);

// >>> bench/tb_top.sv
// self-checking bench for the page-0 upper register bank
`timescale 1ns/1ns
module tb_top;
  logic                     clock_i, rst_i, dacs, evt, det, clr, page;
  logic [15:0]              legacy, decay;
  logic [3:0]               ratio;
  logic [7:0]               rdata, d, wv;
  cara_pkg::cara_reg_req_t  req;
  cara_pkg::cara_adc_path_t path;
  cara_pkg::cara_bypass_t   byp;
  cara_pkg::cara_dac_cur_t  cur;
  int                       n_mismatch = 0;
  int                       n_compared = 0;
  logic [1:0]               cc [3] = '{2'h0, 2'h1, 2'h3};
  // ratio, register byte, expected decay in ms
  logic [27:0] tbl [13] = '{{4'hA, 8'hA8, 16'h0258}, {4'h0, 8'hFC, 16'h0FA0},
    {4'h1, 8'hFC, 16'h15E0}, {4'hA, 8'hFC, 16'h5780}, {4'h2, 8'hD4, 16'h1F40},
    {4'h1, 8'hD4, 16'h15E0}, {4'h6, 8'h80, 16'h0032}, {4'h3, 8'hFC, 16'h2580},
    {4'h4, 8'hFC, 16'h2BC0}, {4'h5, 8'hFC, 16'h2BC0}, {4'h7, 8'hFC, 16'h3E80},
    {4'h8, 8'hFC, 16'h4B00}, {4'h9, 8'hFC, 16'h5780}};

  cara_host_model host (.clock_i(clock_i), .rdata_i(rdata), .req_o(req));
  cara_regs uut (.clock_i(clock_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
    .page_o(page), .legacy_decay_ms_i(legacy), .adc_decimation_ratio_i(ratio),
    .dacs_powered_down_i(dacs), .bus_error_event_i(evt), .right_decay_ms_o(decay),
    .adc_path_o(path), .bus_detect_on_o(det), .bus_error_clear_o(clr),
    .bypass_o(byp), .dac_current_o(cur));

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // 10 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  // watchdog: a hang counts as a mismatch
  initial begin
    #1000000;
    n_mismatch++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_i, dacs, evt, legacy, ratio} = {3'b100, 16'h1234, 4'h0};
    repeat (6) @(posedge clock_i);
    #10 rst_i = 1'b0;
    for (int a = 8'h6A; a <= 8'h6D; a++) begin
      host.rd(a[6:0], d);
      check("reset", d, 16'h0000);
    end
    check("legacy", decay, 16'h1234);
    for (int i = 0; i < 8; i++) begin
      host.wr(7'h6C, 8'h01 << i); // one switch at a time
      check("bypass", byp, 16'h0001 << i);
      host.rd(7'h6C, d);
      check("bypass rd", d, 16'h0001 << i);
    end
    foreach (cc[k]) begin
      host.wr(7'h6D, {cc[k], 6'h00}); // reserved bits zero
      check("dac cur", cur, cc[k]);
    end
    dacs = 1'b1;
    for (int m = 0; m < 4; m++) begin
      wv = {m[1], ~m[0], m[1:0], 4'hD}; // d1 zero, read-only d0 set
      host.wr(7'h6B, wv);
      check("hpf mic", path[4:1], wv[7:4]);
      check("det on", det, wv[2]);
      host.rd(7'h6B, d);
      check("prog on", path.prog_filter_on, 16'h0001);
      check("path rd", d, wv & 8'hFC);
    end
    dacs = 1'b0;
    @(posedge clock_i) #10 evt = 1'b1;
    check("prog off", path.prog_filter_on, 16'h0000);
    @(posedge clock_i) #10 evt = 1'b0;
    check("clr", clr, 16'h0001);
    @(posedge clock_i) #10 check("clr end", clr, 16'h0000);
    host.rd(7'h6B, d);
    check("err set", d, (wv & 8'hFC) | 8'h01);
    host.rd(7'h6B, d);
    check("err gone", d, wv & 8'hFC);
    host.wr(7'h6B, 8'h00);
    check("det off", det, 16'h0000);
    evt = 1'b1;
    @(posedge clock_i) #10 evt = 1'b0;
    check("no clr", clr, 16'h0000);
    host.rd(7'h6B, d);
    check("err off", d, 16'h0000);
    foreach (tbl[k]) begin
      ratio = tbl[k][27:24];
      host.wr(7'h6A, tbl[k][23:16]);
      host.rd(7'h6A, d); // also passes the edge the derived decay needs
      check("decay", decay, tbl[k][15:0]);
      check("decay rd", d, tbl[k][23:16]);
    end
    host.wr(7'h6A, 8'h7C);
    @(posedge clock_i) #10 check("legacy back", decay, 16'h1234);
    host.wr(7'h50, 8'hFF); // unmapped write dropped; reserved ones never written
    host.rd(7'h7F, d);
    check("rsvd 7F", d, 16'h0000);
    host.rd(7'h6E, d);
    check("rsvd 6E", d, 16'h0000);
    host.rd(7'h50, d);
    check("unmapped", d, 16'h0000);
    host.wr(7'h00, 8'h01);
    check("page", page, 16'h0001);
    host.rd(7'h00, d);
    check("page rd", d, 16'h0001);
    host.wr(7'h6C, 8'h00);
    check("page1 wr", byp, 16'h0080);
    host.rd(7'h6C, d);
    check("page1 rd", d, 16'h0000);
    host.wr(7'h00, 8'h00);
    check("page back", page, 16'h0000);
    host.rd(7'h00, d);
    check("page back rd", d, 16'h0000);
    finish_test();
  end
endmodule
